/* common/gfs_pkg.sv */
/*
 * Package for the genset fault-shutdown supervisor: timing figures, derived
 * cycle counts, the sequencer state enum and the switch contact struct.
 * Assumes a single 20 MHz system clock.
 */
package gfs_pkg;
    localparam int unsigned CLK_HZ        = 20_000_000; // System clock rate
    localparam int unsigned OVERSPEED_HZ  = 70;         // Trip frequency
    localparam int unsigned CRANK_S       = 8;          // Crank period
    localparam int unsigned REST_S        = 3;          // Rest period
    localparam int unsigned PERSIST_S     = 6;          // Within 5 to 8 s
    localparam int unsigned GATE_MS       = 1000;       // Frequency gate
    localparam int unsigned CRANK_TRIES   = 3;          // Crank/rest cycles
    // Derived cycle counts
    localparam int unsigned CRANK_CYC   = CRANK_S * CLK_HZ;
    localparam int unsigned REST_CYC    = REST_S * CLK_HZ;
    localparam int unsigned PERSIST_CYC = PERSIST_S * CLK_HZ;
    localparam int unsigned GATE_CYC    = (GATE_MS * (CLK_HZ / 1000));
    localparam int unsigned OVER_EDGES  = OVERSPEED_HZ * GATE_MS / 1000;

    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        GFS_IDLE  = 5'h01,
        GFS_CRANK = 5'h02,
        GFS_REST  = 5'h04,
        GFS_RUN   = 5'h08,
        GFS_FAULT = 5'h10
    } gfs_state_t;

    // Engine switch contacts, true when the contact is grounded
    typedef struct packed {
        logic oil;  // Oil pressure low
        logic cool; // Coolant level low
        logic temp; // Engine overtemperature
    } gfs_sw_t;
endpackage : gfs_pkg

/* verilog/gfs_supervisor.sv */
/*
 * Genset fault-shutdown supervisor: crank sequencing, overspeed detection,
 * debounced switch faults and latched shutdown with fault lamp.
 * Assumes switch contacts and the speed pulse come straight from pins and
 * the master selector is a level, high in the run position.
 */
`timescale 1ns/1ns
`default_nettype none
module gfs_supervisor #(
    parameter int unsigned CRANK_CYC   = gfs_pkg::CRANK_CYC,   // Crank time
    parameter int unsigned REST_CYC    = gfs_pkg::REST_CYC,    // Rest time
    parameter int unsigned PERSIST_CYC = gfs_pkg::PERSIST_CYC, // Fault delay
    parameter int unsigned GATE_CYC    = gfs_pkg::GATE_CYC,    // Freq gate
    parameter int unsigned OVER_EDGES  = gfs_pkg::OVER_EDGES,  // Trip edges
    parameter int unsigned START_EDGES = 10                    // Start edges
) (
    input  wire logic       clk_sys,                 // 20 MHz clock
    input  wire logic       resetn,                  // Async reset, low
    input  wire logic       run_select,              // Selector in run
    input  wire logic       speed_pulse,             // Engine output wave
    input  wire logic       oil_pressure_low_input,  // Low when grounded
    input  wire logic       coolant_level_low_input, // Low when grounded
    input  wire logic       engine_overtemp_input,   // Low when grounded
    output logic            crank_q,                 // Starter drive
    output logic            fuel_run_q,              // Fuel/ignition on
    output logic            shutdown_q,              // Shutdown active
    output logic            fault_lamp_q,            // Fault lamp
    output logic            overcrank_q              // Overcrank cause
);
    // Two-stage synchronisers on every pin input
    logic [4:0] sync1_q, sync2_q;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sync1_q <= 5'h1c;  // Switches idle high (open)
            sync2_q <= 5'h1c;
        end else begin
            sync1_q <= {oil_pressure_low_input, coolant_level_low_input,
                        engine_overtemp_input, speed_pulse, run_select};
            sync2_q <= sync1_q;
        end
    end
    gfs_pkg::gfs_sw_t sw;   // Grounded contacts as active-high faults
    logic run_s, spd_s;
    assign run_s = sync2_q[0];
    assign spd_s = sync2_q[1];
    assign sw    = ~sync2_q[4:2];

    gfs_pkg::gfs_state_t state_q, state_d; // Sequencer state

    // Speed edge detect and gated edge count over one gate period
    logic        spd_last_q, spd_last_d;
    logic [31:0] gate_q, gate_d, edges_q, edges_d, freq_q, freq_d;
    logic        rise;
    always_comb begin
        rise       = spd_s && !spd_last_q;
        spd_last_d = spd_s;
        gate_d     = gate_q + 32'h1;
        edges_d    = edges_q + {31'h0, rise};
        freq_d     = freq_q;
        if (gate_q == GATE_CYC - 1) begin
            gate_d  = 32'h0;
            edges_d = {31'h0, rise};
            freq_d  = edges_q;  // Edges per gate period = frequency
        end
        // A stopped set must not carry an old reading into its next start,
        // or a quick restart would see a stale start or overspeed at once
        if (state_q == gfs_pkg::GFS_IDLE) begin
            edges_d = 32'h0;
            freq_d  = 32'h0;
        end
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            spd_last_q <= 1'b0;
            gate_q     <= 32'h0;
            edges_q    <= 32'h0;
            freq_q     <= 32'h0;
        end else begin
            spd_last_q <= spd_last_d;
            gate_q     <= gate_d;
            edges_q    <= edges_d;
            freq_q     <= freq_d;
        end
    end
    logic overspeed, started;
    assign overspeed = freq_q > OVER_EDGES;
    assign started   = freq_q >= START_EDGES;  // Engine has caught

    // Persistence timers for the three switch faults, one per switch
    logic [2:0]  sw_trip;
    logic [31:0] pers_q [3];
    logic [31:0] pers_d [3];
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            // Only counts while the set runs; a blip resets the count
            pers_d[i]  = (sw[i] && state_q == gfs_pkg::GFS_RUN)
                         ? pers_q[i] + 32'h1 : 32'h0;
            sw_trip[i] = pers_q[i] >= PERSIST_CYC - 1;
        end
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 3; i++) pers_q[i] <= 32'h0;
        end else begin
            for (int i = 0; i < 3; i++) pers_q[i] <= pers_d[i];
        end
    end

    // Sequencer: crank, rest, run and latched fault
    logic [31:0] tmr_q, tmr_d;
    logic [1:0]  tries_q, tries_d;
    logic        ovc_d, crank_d, fuel_d, shut_d, lamp_d;
    always_comb begin
        state_d = state_q;
        tmr_d   = tmr_q + 32'h1;
        tries_d = tries_q;
        ovc_d   = overcrank_q;
        case (state_q)
            gfs_pkg::GFS_IDLE: begin
                tmr_d   = 32'h0;
                tries_d = 2'h0;
                ovc_d   = 1'b0;
                if (run_s) state_d = gfs_pkg::GFS_CRANK;
            end
            gfs_pkg::GFS_CRANK: begin
                if (!run_s) state_d = gfs_pkg::GFS_IDLE;
                else if (started) state_d = gfs_pkg::GFS_RUN;
                else if (tmr_q == CRANK_CYC - 1) begin
                    state_d = gfs_pkg::GFS_REST;
                    tmr_d   = 32'h0;
                end
            end
            gfs_pkg::GFS_REST: begin
                if (!run_s) state_d = gfs_pkg::GFS_IDLE;
                else if (tmr_q == REST_CYC - 1) begin
                    tmr_d   = 32'h0;
                    tries_d = tries_q + 2'h1;
                    if (tries_q == 2'(gfs_pkg::CRANK_TRIES - 1)) begin
                        state_d = gfs_pkg::GFS_FAULT;
                        ovc_d   = 1'b1;
                    end else begin
                        state_d = gfs_pkg::GFS_CRANK;
                    end
                end
            end
            gfs_pkg::GFS_RUN: begin
                tmr_d = 32'h0;
                if (!run_s) state_d = gfs_pkg::GFS_IDLE;
                else if (overspeed || |sw_trip)
                    state_d = gfs_pkg::GFS_FAULT;
            end
            gfs_pkg::GFS_FAULT: begin
                tmr_d = 32'h0;
                // Latched; only leaving run clears it
                if (!run_s) state_d = gfs_pkg::GFS_IDLE;
            end
            default: state_d = gfs_pkg::GFS_IDLE;
        endcase
        crank_d = state_d == gfs_pkg::GFS_CRANK;
        fuel_d  = state_d == gfs_pkg::GFS_CRANK || state_d == gfs_pkg::GFS_RUN;
        shut_d  = state_d == gfs_pkg::GFS_FAULT;
        lamp_d  = state_d == gfs_pkg::GFS_FAULT;
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_q      <= gfs_pkg::GFS_IDLE;
            tmr_q        <= 32'h0;
            tries_q      <= 2'h0;
            overcrank_q  <= 1'b0;
            crank_q      <= 1'b0;
            fuel_run_q   <= 1'b0;
            shutdown_q   <= 1'b0;
            fault_lamp_q <= 1'b0;
        end else begin
            state_q      <= state_d;
            tmr_q        <= tmr_d;
            tries_q      <= tries_d;
            overcrank_q  <= ovc_d;
            crank_q      <= crank_d;
            fuel_run_q   <= fuel_d;
            shutdown_q   <= shut_d;
            fault_lamp_q <= lamp_d;
        end
    end

    // Checks
    property p_overspeed;
        @(posedge clk_sys) disable iff (!resetn)
        (state_q == gfs_pkg::GFS_RUN && run_s && overspeed)
            |=> (shutdown_q && fault_lamp_q);
    endproperty
    a_overspeed: assert property (p_overspeed)
        else $error("overspeed did not shut down");
    property p_oil;
        @(posedge clk_sys) disable iff (!resetn)
        (state_q == gfs_pkg::GFS_RUN && run_s && sw_trip[2])
            |=> (shutdown_q && fault_lamp_q);
    endproperty
    a_oil: assert property (p_oil)
        else $error("oil fault did not light lamp");
    property p_cool;
        @(posedge clk_sys) disable iff (!resetn)
        (state_q == gfs_pkg::GFS_RUN && run_s && sw_trip[1])
            |=> (shutdown_q && fault_lamp_q);
    endproperty
    a_cool: assert property (p_cool)
        else $error("coolant fault did not shut down");
    property p_temp;
        @(posedge clk_sys) disable iff (!resetn)
        (state_q == gfs_pkg::GFS_RUN && run_s && sw_trip[0])
            |=> (shutdown_q && fault_lamp_q);
    endproperty
    a_temp: assert property (p_temp)
        else $error("overtemp fault did not shut down");
    property p_crank;
        @(posedge clk_sys) disable iff (!resetn)
        $rose(crank_q) |-> ($past(run_s) && state_q == gfs_pkg::GFS_CRANK);
    endproperty
    a_crank: assert property (p_crank)
        else $error("crank without run select");
    property p_ovc;
        @(posedge clk_sys) disable iff (!resetn)
        $rose(overcrank_q) |-> (fault_lamp_q && !crank_q && tries_q == 2'h3);
    endproperty
    a_ovc: assert property (p_ovc)
        else $error("overcrank state inconsistent");
    property p_latch;
        @(posedge clk_sys) disable iff (!resetn)
        (fault_lamp_q && run_s) |=> fault_lamp_q;
    endproperty
    a_latch: assert property (p_latch)
        else $error("fault cleared while still in run");
    property p_nofuel;
        @(posedge clk_sys) disable iff (!resetn)
        shutdown_q |-> (!fuel_run_q && !crank_q);
    endproperty
    a_nofuel: assert property (p_nofuel)
        else $error("engine driven during shutdown");
endmodule : gfs_supervisor
`default_nettype wire

/* testbench/gfs_engine_model.sv */
/* Engine-side model for the supervisor: speed sensor and three switches.
   Assumes the bench picks the speed period and the grounded contacts. */
`timescale 1ns/1ns
`default_nettype none
module gfs_engine_model (
    input  wire logic             clk_sys,     // System clock
    input  wire logic             crank,       // Starter engaged
    input  wire logic             fuel_on,     // Fuel/ignition on
    input  wire logic             will_start,  // Engine able to fire
    input  wire logic [7:0]       period,      // Speed period, cycles
    input  wire gfs_pkg::gfs_sw_t grounded,    // Contacts grounded
    output logic                  speed_pulse, // Speed waveform
    output logic                  oil_n,       // Oil contact
    output logic                  cool_n,      // Coolant contact
    output logic                  temp_n       // Overtemp contact
);
    logic       running = 1'b0; // Engine firing
    logic [7:0] cnt = 8'h00;    // Phase within one speed period
    // Catches only while cranked, then keeps firing; stalls as soon as fuel is cut
    always @(posedge clk_sys) begin
        if (!fuel_on) running <= 1'b0;
        else if (crank && will_start) running <= 1'b1;
        cnt <= (cnt + 8'h01 >= period) ? 8'h00 : cnt + 8'h01;
    end
    // A stopped engine gives no pulses, so the line rests low
    assign speed_pulse = running && (cnt < (period >> 1));
    // Open contacts are pulled up; grounded ones read low
    assign oil_n  = !grounded.oil;
    assign cool_n = !grounded.cool;
    assign temp_n = !grounded.temp;
endmodule : gfs_engine_model
`default_nettype wire

/* testbench/test_genset_fault_shutdown.sv */
/* Bench for the supervisor: crank cycling, overcrank, overspeed and switch
   faults. Assumes the engine model stands on the far side of the pins. */
`timescale 1ns/1ns
`default_nettype none
module test_genset_fault_shutdown;
    localparam int PERSIST = 60; // Shortened persistence
    localparam int GATE    = 40; // Shortened frequency gate
    typedef struct { logic [2:0] flags; int lo; int hi; } gfs_note_t;
    logic clk_sys = 1'b0, resetn = 1'b0, run_select = 1'b0;
    logic will_start = 1'b0, speed_pulse, oil_n, cool_n, temp_n;
    logic crank_q, fuel_run_q, shutdown_q, fault_lamp_q, overcrank_q;
    logic [7:0]       period = 8'h05; // Engine speed period
    gfs_pkg::gfs_sw_t sw = '0;        // Grounded contacts
    int fail_count = 0, total_checks = 0, cyc = 0, t0 = 0, c0 = 0, k, n;
    int seed = 32'hb99e;              // Fixed random seed
    int crank_exp[$];                 // Expected crank lengths
    gfs_note_t note_q[$];             // Expected shutdowns
    gfs_note_t nt;
    bit crank_was = 0, shut_was = 0;

    always #25 clk_sys = ~clk_sys; // 20 MHz

    gfs_supervisor #(.CRANK_CYC(80), .REST_CYC(30), .PERSIST_CYC(PERSIST),
        .GATE_CYC(GATE), .OVER_EDGES(8), .START_EDGES(2)) dut (
        .clk_sys(clk_sys), .resetn(resetn), .run_select(run_select),
        .speed_pulse(speed_pulse), .oil_pressure_low_input(oil_n),
        .coolant_level_low_input(cool_n), .engine_overtemp_input(temp_n),
        .crank_q(crank_q), .fuel_run_q(fuel_run_q), .shutdown_q(shutdown_q),
        .fault_lamp_q(fault_lamp_q), .overcrank_q(overcrank_q));

    gfs_engine_model engine (.clk_sys(clk_sys), .crank(crank_q),
        .fuel_on(fuel_run_q), .will_start(will_start), .period(period),
        .grounded(sw), .speed_pulse(speed_pulse), .oil_n(oil_n),
        .cool_n(cool_n), .temp_n(temp_n));

    task automatic compare_bits(string nm, logic [2:0] e, logic [2:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask : compare_bits

    task automatic compare_range(string nm, int lo, int hi, int g);
        total_checks++;
        if (g < lo || g > hi) begin
            fail_count++;
            $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask : compare_range

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    // Bounded wait for the latched shutdown
    task automatic wait_shut(int bound);
        for (k = 0; k < bound && shutdown_q !== 1'b1; k++) @(negedge clk_sys);
        compare_bits("shutdown", 3'h1, {2'h0, shutdown_q});
    endtask : wait_shut

    // Selector to run and wait until cranking hands over to running
    task automatic start_engine();
        will_start = 1'b1;
        run_select = 1'b1;
        for (k = 0; k < 300 && !(fuel_run_q === 1'b1 && crank_q === 1'b0
             && k > 8); k++) @(negedge clk_sys);
        repeat (2 * GATE) @(negedge clk_sys);
        compare_bits("running", 3'h2,
            {crank_q, fuel_run_q, shutdown_q});
    endtask : start_engine

    // Off the selector; shutdown, lamp and crank must be clear six cycles later
    task automatic stop_all();
        run_select = 1'b0;
        will_start = 1'b0;
        sw = '0;
        repeat (6) @(negedge clk_sys);
        compare_bits("outputs off", 3'h0,
            {shutdown_q, fault_lamp_q, crank_q});
    endtask : stop_all

    // Cycles counted on the rising edge so stimulus and watcher agree
    always @(posedge clk_sys) cyc++;

    // Watch outputs; each crank fall or shutdown rise takes the oldest note
    always @(negedge clk_sys) begin
        if (crank_q === 1'b1 && !crank_was) c0 = cyc;
        if (crank_q !== 1'b1 && crank_was && crank_exp.size() > 0) begin
            n = crank_exp.pop_front();
            compare_range("crank length", n, n, cyc - c0);
        end
        if (shutdown_q === 1'b1 && !shut_was && note_q.size() > 0) begin
            nt = note_q.pop_front();
            compare_bits("fault flags", nt.flags,
                {shutdown_q, fault_lamp_q, overcrank_q});
            compare_range("trip delay", nt.lo, nt.hi, cyc - t0);
        end
        crank_was = (crank_q === 1'b1);
        shut_was = (shutdown_q === 1'b1);
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        print_verdict();
    end

    initial begin
        repeat (8) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (2) @(negedge clk_sys);
        // Engine never fires: three crank/rest cycles, then overcrank
        repeat (3) crank_exp.push_back(80);
        note_q.push_back('{3'h7, 330, 340});
        t0 = cyc;
        run_select = 1'b1;
        wait_shut(600);
        repeat (100) @(negedge clk_sys);
        compare_bits("held", 3'h6, {shutdown_q, fault_lamp_q, crank_q});
        stop_all();
        // Speed at exactly the trip count must not trip; above it must
        start_engine();
        repeat (300) @(negedge clk_sys);
        compare_bits("no trip", 3'h0, {2'h0, shutdown_q});
        note_q.push_back('{3'h6, 1, 2 * GATE + 10});
        t0 = cyc;
        period = 8'h04;
        wait_shut(300);
        stop_all();
        period = 8'h05;
        // Each switch: two short groundings, then a persistent one
        for (int i = 0; i < 3; i++) begin
            start_engine();
            repeat (2) begin
                sw[i] = 1'b1;
                repeat (10 + $unsigned($random(seed)) % 40) @(negedge clk_sys);
                sw[i] = 1'b0;
                repeat (5) @(negedge clk_sys);
            end
            compare_bits("short fault", 3'h0, {2'h0, shutdown_q});
            note_q.push_back('{3'h6, PERSIST, PERSIST + 8});
            t0 = cyc;
            sw[i] = 1'b1;
            wait_shut(200);
            stop_all();
        end
        print_verdict();
    end
endmodule : test_genset_fault_shutdown
`default_nettype wire
